/* File: logic/asrs_status.sv */
`timescale 1ns/1ps
`default_nettype none
module asrs_status #(
  parameter int ADDR_W = 8
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [2:0] i_acq,
  input wire logic [2:0] i_axis_en,
  input wire asrs_pkg::asrs_sample_t i_sample,
  input wire logic [1:0] i_queue_mode,
  input wire asrs_pkg::asrs_queue_t i_queue,
  input wire logic i_fast_read,
  input wire asrs_pkg::asrs_rd_req_t i_rd,
  output asrs_pkg::asrs_rd_rsp_t o_rd,
  output logic [7:0] o_rd_ptr
);

  typedef struct packed {
    logic zyxdr;
    logic zyxow;
    logic [2:0] rd_seen;
    logic [ADDR_W-1:0] ptr;
    logic [7:0] x_lsb;
    logic [7:0] y_lsb;
    logic [7:0] z_lsb;
    asrs_pkg::asrs_rd_rsp_t rsp;
  } asrs_state_t;

  asrs_state_t st_r;
  asrs_state_t st_nxt;

  logic [2:0] acq;
  logic [2:0] msb_rd;
  logic [2:0] dr;
  logic [2:0] ow;
  logic [2:0] ow_event;
  logic [2:0] seen_upd;
  logic queue_off;
  logic take;
  logic all_read;
  logic [7:0] addr;
  logic [7:0] last_addr;
  logic [7:0] y_msb_addr;
  logic [7:0] z_msb_addr;
  logic [7:0] flags_byte;
  logic [7:0] queue_byte;
  logic [7:0] rd_byte;

  // acquisitions of disabled channels are ignored
  assign acq = i_acq & i_axis_en;

  // one fresh and overrun flag pair per axis
  genvar gi;
  generate
    for (gi = 0; gi < asrs_pkg::NUM_AXES; gi++) begin : g_axis
      asrs_axis_flags u_flags (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_acq(acq[gi]),
        .i_msb_rd(msb_rd[gi]),
        .o_dr(dr[gi]),
        .o_ow(ow[gi]),
        .o_ow_event(ow_event[gi])
      );
    end
  endgenerate

  always_comb begin
    queue_off = (i_queue_mode == asrs_pkg::QMODE_OFF);
    take = i_rd.req;
    // pointer held at ADDR_W bits, bus side fixed at 8
    addr = i_rd.load ? i_rd.addr : 8'(st_r.ptr);
    last_addr = i_fast_read ? asrs_pkg::ADDR_LAST_FAST : asrs_pkg::ADDR_LAST_WIDE;
    y_msb_addr = i_fast_read ? asrs_pkg::ADDR_FAST_Y_MSB : asrs_pkg::ADDR_Y_MSB;
    z_msb_addr = i_fast_read ? asrs_pkg::ADDR_FAST_Z_MSB : asrs_pkg::ADDR_Z_MSB;
    // high byte reads clear flags only while the flags are on view
    msb_rd[asrs_pkg::AXIS_X] = take && queue_off && (addr == asrs_pkg::ADDR_X_MSB);
    msb_rd[asrs_pkg::AXIS_Y] = take && queue_off && (addr == y_msb_addr);
    msb_rd[asrs_pkg::AXIS_Z] = take && queue_off && (addr == z_msb_addr);
  end

  // status byte layouts
  always_comb begin
    flags_byte = asrs_pkg::STATUS_RESET;
    flags_byte[asrs_pkg::BIT_ZYXOW] = st_r.zyxow;
    flags_byte[asrs_pkg::BIT_ZOW] = ow[asrs_pkg::AXIS_Z];
    flags_byte[asrs_pkg::BIT_YOW] = ow[asrs_pkg::AXIS_Y];
    flags_byte[asrs_pkg::BIT_XOW] = ow[asrs_pkg::AXIS_X];
    flags_byte[asrs_pkg::BIT_ZYXDR] = st_r.zyxdr;
    flags_byte[asrs_pkg::BIT_ZDR] = dr[asrs_pkg::AXIS_Z];
    flags_byte[asrs_pkg::BIT_YDR] = dr[asrs_pkg::AXIS_Y];
    flags_byte[asrs_pkg::BIT_XDR] = dr[asrs_pkg::AXIS_X];
    // queue view: overflow, watermark, sample count
    queue_byte = {i_queue.ovf, i_queue.wmrk, i_queue.cnt};
  end

  // read data mux
  always_comb begin
    rd_byte = asrs_pkg::UNMAPPED_DATA;
    if (addr == asrs_pkg::ADDR_STATUS) begin
      rd_byte = queue_off ? flags_byte : queue_byte;
    end else if (i_fast_read) begin
      case (addr)
        asrs_pkg::ADDR_X_MSB: begin
          rd_byte = i_sample.x[15:8];
        end
        asrs_pkg::ADDR_FAST_Y_MSB: begin
          rd_byte = i_sample.y[15:8];
        end
        asrs_pkg::ADDR_FAST_Z_MSB: begin
          rd_byte = i_sample.z[15:8];
        end
        default: begin
          rd_byte = asrs_pkg::UNMAPPED_DATA;
        end
      endcase
    end else begin
      case (addr)
        asrs_pkg::ADDR_X_MSB: begin
          rd_byte = i_sample.x[15:8];
        end
        asrs_pkg::ADDR_X_LSB: begin
          rd_byte = st_r.x_lsb;
        end
        asrs_pkg::ADDR_Y_MSB: begin
          rd_byte = i_sample.y[15:8];
        end
        asrs_pkg::ADDR_Y_LSB: begin
          rd_byte = st_r.y_lsb;
        end
        asrs_pkg::ADDR_Z_MSB: begin
          rd_byte = i_sample.z[15:8];
        end
        asrs_pkg::ADDR_Z_LSB: begin
          rd_byte = st_r.z_lsb;
        end
        default: begin
          rd_byte = asrs_pkg::UNMAPPED_DATA;
        end
      endcase
    end
  end

  // all-axis tracking: a fresh acquisition marks its axis unread again
  always_comb begin
    seen_upd = (st_r.rd_seen | msb_rd) & ~acq;
    all_read = (&seen_upd) && (|msb_rd);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.valid = 1'b0;
    st_nxt.rd_seen = seen_upd;
    if (take) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.data = rd_byte;
      // burst pointer returns to the status slot after the last data byte
      if (addr >= last_addr) begin
        st_nxt.ptr = ADDR_W'(asrs_pkg::ADDR_STATUS);
      end else begin
        st_nxt.ptr = ADDR_W'(addr + 8'h01);
      end
    end
    // low bytes frozen at the high byte read only while the flags are on view, so the pair stays coherent there
    if (msb_rd[asrs_pkg::AXIS_X]) begin
      st_nxt.x_lsb = i_sample.x[7:0];
    end
    if (msb_rd[asrs_pkg::AXIS_Y]) begin
      st_nxt.y_lsb = i_sample.y[7:0];
    end
    if (msb_rd[asrs_pkg::AXIS_Z]) begin
      st_nxt.z_lsb = i_sample.z[7:0];
    end
    if (all_read) begin
      st_nxt.zyxdr = 1'b0;
      st_nxt.zyxow = 1'b0;
      st_nxt.rd_seen = 3'h0;
    end
    // set wins over clear in the same cycle
    if (|acq) begin
      st_nxt.zyxdr = 1'b1;
    end
    if (|ow_event) begin
      st_nxt.zyxow = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // both bus outputs straight from flip-flops
  // answer lags the taken edge by exactly one cycle
  assign o_rd = st_r.rsp;
  assign o_rd_ptr = 8'(st_r.ptr);

endmodule
`default_nettype wire

/* File: logic/asrs_pkg.sv */
`default_nettype none
package asrs_pkg;

  // register addresses, normal (two bytes per axis) layout
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_X_MSB = 8'h01;
  localparam logic [7:0] ADDR_X_LSB = 8'h02;
  localparam logic [7:0] ADDR_Y_MSB = 8'h03;
  localparam logic [7:0] ADDR_Y_LSB = 8'h04;
  localparam logic [7:0] ADDR_Z_MSB = 8'h05;
  localparam logic [7:0] ADDR_Z_LSB = 8'h06;
  localparam logic [7:0] ADDR_LAST_WIDE = 8'h06;

  // fast (high byte only) layout
  localparam logic [7:0] ADDR_FAST_Y_MSB = 8'h02;
  localparam logic [7:0] ADDR_FAST_Z_MSB = 8'h03;
  localparam logic [7:0] ADDR_LAST_FAST = 8'h03;

  // sample_ready_flags field positions
  localparam int BIT_ZYXOW = 7;
  localparam int BIT_ZOW = 6;
  localparam int BIT_YOW = 5;
  localparam int BIT_XOW = 4;
  localparam int BIT_ZYXDR = 3;
  localparam int BIT_ZDR = 2;
  localparam int BIT_YDR = 1;
  localparam int BIT_XDR = 0;

  // shared_status_slot queue view field positions
  localparam int BIT_Q_OVF = 7;
  localparam int BIT_Q_WMRK = 6;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [1:0] QMODE_OFF = 2'h0;
  localparam int NUM_AXES = 3;
  localparam int AXIS_X = 0;
  localparam int AXIS_Y = 1;
  localparam int AXIS_Z = 2;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } asrs_sample_t;

  typedef struct packed {
    logic ovf;
    logic wmrk;
    logic [5:0] cnt;
  } asrs_queue_t;

  typedef struct packed {
    logic req;
    logic load;
    logic [7:0] addr;
  } asrs_rd_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } asrs_rd_rsp_t;

endpackage
`default_nettype wire

/* File: logic/asrs_axis_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module asrs_axis_flags (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_acq,
  input wire logic i_msb_rd,
  output logic o_dr,
  output logic o_ow,
  output logic o_ow_event
);

  typedef struct packed {
    logic dr;
    logic ow;
  } asrs_axis_state_t;

  asrs_axis_state_t st_r;
  asrs_axis_state_t st_nxt;

  // overwrite only if the previous value was not read in this same cycle
  assign o_ow_event = i_acq && st_r.dr && !i_msb_rd;

  always_comb begin
    st_nxt = st_r;
    if (i_msb_rd) begin
      st_nxt.dr = 1'b0;
      st_nxt.ow = 1'b0;
    end
    if (i_acq) begin
      st_nxt.dr = 1'b1;
    end
    if (o_ow_event) begin
      st_nxt.ow = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_dr = st_r.dr;
  assign o_ow = st_r.ow;

endmodule
`default_nettype wire

/* File: sim/asrs_status_props.sv */
`timescale 1ns/1ps
`default_nettype none
module asrs_status_props (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [2:0] i_acq,
  input wire logic [2:0] i_axis_en,
  input wire asrs_pkg::asrs_sample_t i_sample,
  input wire logic [1:0] i_queue_mode,
  input wire asrs_pkg::asrs_queue_t i_queue,
  input wire logic i_fast_read,
  input wire asrs_pkg::asrs_rd_req_t i_rd,
  input wire asrs_pkg::asrs_rd_rsp_t o_rd,
  input wire logic [7:0] o_rd_ptr
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // loaded status read, and the same in flags view
  wire logic ld0 = i_rd.req && i_rd.load && i_rd.addr == 8'h00;
  wire logic sr = ld0 && i_queue_mode == 2'h0;
  chk_rd_valid: assert property (o_rd.valid == $past(i_rd.req)) else $error("late answer");
  chk_ptr_load: assert property (ld0 |=> o_rd_ptr == 8'h01) else $error("bad pointer");
  chk_reset_clean: assert property ($rose(i_nrst) |-> o_rd == '0 && o_rd_ptr == 8'h00) else $error("reset");
  chk_queue_view: assert property (ld0 && i_queue_mode != 2'h0 |=> o_rd.data == $past(i_queue))
    else $error("queue view");
  chk_x_set: assert property (i_acq[0] && i_axis_en[0] ##1 sr |=> o_rd.data[0] && o_rd.data[3])
    else $error("x fresh");
  chk_x_clear: assert property (i_rd.req && i_rd.load && i_rd.addr == 8'h01 && !i_acq[0] && i_queue_mode == 2'h0
    ##1 sr |=> !o_rd.data[0] && !o_rd.data[4]) else $error("x clear");
  chk_z_over: assert property (i_acq[2] && i_axis_en[2] ##1 i_acq[2] && i_axis_en[2] && !i_rd.req ##1 sr
    |=> o_rd.data[6] && o_rd.data[7]) else $error("z over");
  chk_fast_y: assert property (i_fast_read && i_rd.req && i_rd.load && i_rd.addr == 8'h02
    |=> o_rd.data == $past(i_sample.y[15:8])) else $error("fast y");
endmodule
bind asrs_status asrs_status_props props_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_acq(i_acq),
  .i_axis_en(i_axis_en), .i_sample(i_sample), .i_queue_mode(i_queue_mode), .i_queue(i_queue),
  .i_fast_read(i_fast_read), .i_rd(i_rd), .o_rd(o_rd), .o_rd_ptr(o_rd_ptr));
`default_nettype wire

/* File: sim/asrs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asrs_host_model (
  input wire logic i_clock,
  input wire asrs_pkg::asrs_rd_rsp_t i_rsp,
  output var asrs_pkg::asrs_rd_req_t o_req
);
  initial o_req = '0;
  // one byte read; a missing answer comes back inverted
  task automatic rd(input logic ld, input logic [7:0] ad, output logic [7:0] d);
    o_req = '{req: 1'b1, load: ld, addr: ad};
    @(posedge i_clock);
    #1;
    d = i_rsp.valid ? i_rsp.data : ~i_rsp.data;
  endtask
  task automatic idle();
    o_req.req = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: sim/asrs_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module asrs_status_tb_top;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_fast_read = 1'b0;
  logic [2:0] i_acq = '0;
  logic [2:0] i_axis_en = '1;
  logic [2:0] seen = '0;
  logic [1:0] i_queue_mode = '0;
  logic [7:0] o_rd_ptr, d;
  logic [7:0] ex = '0;
  asrs_pkg::asrs_sample_t i_sample = '0;
  asrs_pkg::asrs_queue_t i_queue = '0;
  asrs_pkg::asrs_rd_req_t i_rd;
  asrs_pkg::asrs_rd_rsp_t o_rd;
  int n_errors = 0, checks = 0, seed = 55, a, n;
  always #4 i_clock = ~i_clock;
  asrs_status dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_acq(i_acq), .i_axis_en(i_axis_en), .i_sample(i_sample),
    .i_queue_mode(i_queue_mode), .i_queue(i_queue), .i_fast_read(i_fast_read), .i_rd(i_rd), .o_rd(o_rd),
    .o_rd_ptr(o_rd_ptr));
  asrs_host_model host_u (.i_clock(i_clock), .i_rsp(o_rd), .o_req(i_rd));
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] hi(int x, logic lo);
    return i_sample[16 * x + (lo ? 0 : 8) +: 8];
  endfunction
  // expected flags after an acquisition and after a high byte read
  function automatic void f_acq(int x);
    if (i_axis_en[x]) begin
      ex = ex | (ex[x] ? 8'h80 | (8'h10 << x) : 8'h00) | 8'h08 | (8'h01 << x);
      seen[x] = 1'b0;
    end
  endfunction
  // all-axis flags clear once every axis is read since its last acquisition
  function automatic void f_rd(int x);
    if (i_queue_mode == 2'h0) begin
      ex = ex & ~(8'h11 << x);
      seen[x] = 1'b1;
      if (seen == 3'h7) begin
        ex = ex & 8'h77;
        seen = 3'h0;
      end
    end
  endfunction
  task automatic acq(int x);
    i_sample = 48'({$random(seed), $random(seed)});
    i_acq = 3'h1 << x;
    f_acq(x);
    @(posedge i_clock);
    #1;
  endtask
  task automatic sts();
    host_u.rd(1'b1, 8'h00, d);
    chk("status", d, i_queue_mode == 2'h0 ? ex : 8'(i_queue));
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    chk("ptr", o_rd_ptr, 8'h00);
    sts();
    for (int i = 0; i < 80; i++) begin
      i_axis_en = 3'($random(seed));
      i_fast_read = 1'($random(seed));
      i_queue_mode = 2'($random(seed));
      i_queue = 8'($random(seed));
      a = $unsigned($random(seed)) % 3;
      if ($random(seed) & 1) begin
        host_u.idle();
        acq(a);
        i_acq = 3'h0;
      end else begin
        host_u.rd(1'b1, i_fast_read ? 8'(a + 1) : 8'(2 * a + 1), d);
        chk("high", d, hi(a, 1'b0));
        f_rd(a);
      end
      sts();
    end
    i_queue_mode = 2'h0;
    i_axis_en = 3'h7;
    for (int f = 0; f < 2; f++) begin
      i_fast_read = f[0];
      for (int x = 0; x < 6; x++) begin
        acq(x / 2);
      end
      i_acq = 3'h0;
      n = f ? 4 : 7;
      for (int k = 0; k <= n; k++) begin
        host_u.rd(k == 0, 8'h00, d);
        chk("burst", d, k % n == 0 ? ex : f ? hi(k - 1, 1'b0) : hi((k - 1) / 2, k % 2 == 0));
        if (k % n != 0 && (f || k % 2 == 1)) f_rd(f ? k - 1 : k / 2);
      end
      host_u.idle();
    end
    test_done();
  end
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
